// >>> shared/ccrc_map.svh
/*
 * Register offsets, field positions and reset values of the CRC engine.
 * Assumes a byte-addressed APB bus with one 32-bit word per register.
 */
`ifndef CCRC_MAP_SVH
`define CCRC_MAP_SVH

// Byte offsets on the APB bus.
`define CCRC_OFS_CTRL      8'h00
`define CCRC_OFS_LEN       8'h04
`define CCRC_OFS_WORD_HIGH 8'h08
`define CCRC_OFS_WORD_LOW  8'h0C
`define CCRC_OFS_ACC       8'h10
`define CCRC_OFS_TAPS      8'h14
`define CCRC_OFS_IRQ       8'h18

// Control register fields.
`define CCRC_CTRL_GO       0
`define CCRC_CTRL_AUGMENT  1
`define CCRC_CTRL_ORDER    2
`define CCRC_CTRL_BUSY     3
`define CCRC_CTRL_FULL     4

// Length register fields.
`define CCRC_LEN_WORD_LSB  0
`define CCRC_LEN_POLY_LSB  4

// Interrupt register fields.
`define CCRC_IRQ_FLAG      0
`define CCRC_IRQ_ENABLE    1

// Reset values.
`define CCRC_RST_ACC       16'h0000
`define CCRC_RST_TAPS      16'h0000
`define CCRC_RST_WORD_LEN  4'h0
`define CCRC_RST_POLY_LEN  4'h0

`endif

// >>> shared/ccrc_pkg.sv
/*
 * Types shared by the CRC engine and its bench.
 * Assumes the constants of ccrc_map.svh for offsets and fields.
 */
package ccrc_pkg;

	typedef enum logic [2:0] {
		CCRC_IDLE  = 3'b001,
		CCRC_SHIFT = 3'b010,
		CCRC_AUG   = 3'b100
	} ccrc_state_t;

	typedef struct packed {
		logic       go;
		logic       augment;
		logic       lsb_first;
		logic [3:0] word_len;
		logic [3:0] poly_len;
	} ccrc_cfg_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] word;
	} ccrc_scan_t;

endpackage : ccrc_pkg

// >>> design/ccrc_engine.sv
/*
 * Configurable CRC engine with an APB register slave and a scanner input.
 * Assumes one clock, a synchronous active-high reset and a scanner that
 * runs on the same clock and holds its word until it is accepted.
 * A software byte write in the cycle that a scanner word is offered
 * takes the holding register; scan_ready stays low for that cycle.
 */
// Design decisions made here: the APB interface to the registers and the register offsets.
//
// Contract
// (R1) Accumulator and seed up to sixteen bits.
// (R2) Poly length code n-1 sizes accumulator.
// (R3) Top and bottom terms forced; tap bit0 zero.
// (R4) Taps give all middle polynomial terms.
// (R5) Word length code selects shifted bits.
// (R6) Bits above word length are ignored.
// (R7) XOR feedback shifter via staging shifter.
// (R8) Order clear: shift from word top bit.
// (R9) Order set: shift least significant first.
// (R10) Software seeds accumulator before starting.
// (R11) Low byte write latches and starts word.
// (R12) Accumulator holds check value when done.
// (R13) Augment appends poly-length zero bits.
// (R14) No augment: stop after last bit.
// (R15) Reversed order with augment gives reversed.
// (R16) Software un-reverses with four-step sequence.
// (R17) Busy falling sets done flag always.
// (R18) Only software clears the done flag.
// (R19) Enable bit gates done flag to irq.
// (R20) Sample 0x55667788 gives 0x32D6 or 0x6BA2.
// (R21) Words from software or from scanner.
// (R22) Software writes lengths minus one, two.
// (R23) No processing before start bit set.
// (R24) Full clears when next word accepted.
// (R25) Busy stays until check value valid.
// (R26) One bit per clock into accumulator.
// (R27) Feedback limited to polynomial length.
`timescale 1ns/1ps
`include "ccrc_map.svh"

module ccrc_engine (
	// Clock and reset.
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Program memory scanner words.
	input  wire ccrc_pkg::ccrc_scan_t scan_in,
	output logic                     scan_ready,
	// Completion interrupt request.
	output logic                     irq
);

	////////////////////////////////////////////////////////////////////////
	// Functions.

	// Mask of the low bits up to and including position len.
	function automatic logic [15:0] low_mask(input logic [3:0] len);
		low_mask = 16'hFFFF >> (4'hF - len);
	endfunction : low_mask

	// One step of the division: bit b enters, the top bit feeds back.
	function automatic logic [15:0] crc_step(
		input logic [15:0] acc,
		input logic        b,
		input logic [3:0]  poly_length_code,
		input logic [15:0] taps
	);
		logic [15:0] mask;
		logic [15:0] nxt;
		mask = low_mask(poly_length_code);
		nxt  = {acc[14:0], b} & mask; // [R7] [R26]
		if (acc[poly_length_code]) begin
			nxt = nxt ^ ((taps | 16'h0001) & mask); // [R3] [R4] [R27]
		end
		crc_step = nxt;
	endfunction : crc_step

	// Register select, shared by the write strobes and the error decode.
	function automatic logic reg_hit(input logic [7:0] addr,
	                                 input logic [7:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic                  wr_en;
	logic                  wr_ctrl;
	logic                  wr_len;
	logic                  wr_high;
	logic                  wr_low;
	logic                  wr_acc;
	logic                  wr_taps;
	logic                  wr_irq;
	logic                  mapped;

	assign wr_en   = psel & penable & pwrite;
	assign wr_ctrl = wr_en & reg_hit(paddr, `CCRC_OFS_CTRL);
	assign wr_len  = wr_en & reg_hit(paddr, `CCRC_OFS_LEN);
	assign wr_high = wr_en & reg_hit(paddr, `CCRC_OFS_WORD_HIGH);
	assign wr_low  = wr_en & reg_hit(paddr, `CCRC_OFS_WORD_LOW);
	assign wr_acc  = wr_en & reg_hit(paddr, `CCRC_OFS_ACC);
	assign wr_taps = wr_en & reg_hit(paddr, `CCRC_OFS_TAPS);
	assign wr_irq  = wr_en & reg_hit(paddr, `CCRC_OFS_IRQ);
	assign mapped  = reg_hit(paddr, `CCRC_OFS_CTRL) |
	                 reg_hit(paddr, `CCRC_OFS_LEN) |
	                 reg_hit(paddr, `CCRC_OFS_WORD_HIGH) |
	                 reg_hit(paddr, `CCRC_OFS_WORD_LOW) |
	                 reg_hit(paddr, `CCRC_OFS_ACC) |
	                 reg_hit(paddr, `CCRC_OFS_TAPS) |
	                 reg_hit(paddr, `CCRC_OFS_IRQ);

	// Every access completes in its first access cycle.
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// State.

	ccrc_pkg::ccrc_cfg_t   cfg_q;
	ccrc_pkg::ccrc_state_t state_q;
	logic [15:0]           acc_q;
	logic [15:0]           taps_q;
	logic [15:0]           hold_q;
	logic                  full_q;
	logic [15:0]           shifter_q;
	logic [3:0]            cnt_q;
	logic                  aug_pend_q;
	logic                  busy;
	logic                  busy_q;
	logic                  done_q;
	logic                  ie_q;
	logic                  load;
	logic                  scan_take;
	logic                  data_bit;
	logic [15:0]           word_in;

	assign load       = (state_q == ccrc_pkg::CCRC_IDLE) & cfg_q.go &
	                    full_q; // [R23]
	// A software byte write owns the holding register for that cycle, so
	// the scanner is told to hold rather than losing its word silently.
	assign scan_ready = cfg_q.go & ~full_q &
	                    ~(wr_low | wr_high); // [R21] [R24]
	assign scan_take  = scan_in.valid & scan_ready;
	assign word_in    = hold_q & low_mask(cfg_q.word_len); // [R5] [R6]
	assign data_bit   = cfg_q.lsb_first ? shifter_q[0]   // [R9] [R15]
	                                    : shifter_q[15]; // [R8]
	assign busy       = cfg_q.go & ((state_q != ccrc_pkg::CCRC_IDLE) |
	                    full_q | aug_pend_q); // [R25]

	////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_q.go        <= 1'b0;
			cfg_q.augment   <= 1'b0;
			cfg_q.lsb_first <= 1'b0;
			cfg_q.word_len  <= `CCRC_RST_WORD_LEN;
			cfg_q.poly_len  <= `CCRC_RST_POLY_LEN;
		end else begin
			if (wr_ctrl) begin
				cfg_q.go        <= pwdata[`CCRC_CTRL_GO];
				cfg_q.augment   <= pwdata[`CCRC_CTRL_AUGMENT];
				cfg_q.lsb_first <= pwdata[`CCRC_CTRL_ORDER];
			end
			if (wr_len) begin
				cfg_q.word_len <= pwdata[`CCRC_LEN_WORD_LSB +: 4]; // [R22]
				cfg_q.poly_len <= pwdata[`CCRC_LEN_POLY_LSB +: 4]; // [R2]
			end
		end
	end

	// Bit 0 is not stored, so it always reads back as zero.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			taps_q <= `CCRC_RST_TAPS;
		end else if (wr_taps) begin
			taps_q <= {pwdata[15:1], 1'b0}; // [R3]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input word registers.

	// A low-byte write while a word waits replaces that word's low byte.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hold_q <= 16'h0000;
		end else if (wr_low) begin
			hold_q[7:0] <= pwdata[7:0]; // [R11]
		end else if (wr_high) begin
			hold_q[15:8] <= pwdata[7:0]; // [R24]
		end else if (scan_take) begin
			hold_q <= scan_in.word; // [R21]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			full_q <= 1'b0;
		end else if (wr_low | scan_take) begin
			full_q <= 1'b1; // [R11]
		end else if (load) begin
			full_q <= 1'b0; // [R24]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift sequencer.

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q    <= ccrc_pkg::CCRC_IDLE;
			cnt_q      <= 4'h0;
			aug_pend_q <= 1'b0;
		end else if (!cfg_q.go) begin
			state_q    <= ccrc_pkg::CCRC_IDLE; // [R23]
			aug_pend_q <= 1'b0;
		end else begin
			unique case (state_q)
				ccrc_pkg::CCRC_IDLE: begin
					if (load) begin
						cnt_q      <= cfg_q.word_len; // [R5]
						aug_pend_q <= cfg_q.augment; // [R13] [R14]
						state_q    <= ccrc_pkg::CCRC_SHIFT;
					end else if (aug_pend_q) begin
						cnt_q   <= cfg_q.poly_len; // [R13]
						state_q <= ccrc_pkg::CCRC_AUG;
					end
				end
				ccrc_pkg::CCRC_SHIFT: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						state_q <= ccrc_pkg::CCRC_IDLE; // [R14]
					end
				end
				ccrc_pkg::CCRC_AUG: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h0) begin
						aug_pend_q <= 1'b0;
						state_q    <= ccrc_pkg::CCRC_IDLE;
					end
				end
				default: begin
					state_q <= ccrc_pkg::CCRC_IDLE;
				end
			endcase
		end
	end

	// Left-align so bit 15 is the top data bit; a word shifted LSb first
	// needs no alignment because its first bit already sits at bit 0.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shifter_q <= 16'h0000;
		end else if (load) begin
			shifter_q <= cfg_q.lsb_first ? word_in
			             : word_in << (4'hF - cfg_q.word_len); // [R8]
		end else if (cfg_q.go && state_q == ccrc_pkg::CCRC_SHIFT) begin
			shifter_q <= cfg_q.lsb_first ? {1'b0, shifter_q[15:1]}
			                             : {shifter_q[14:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Accumulator.

	// A software write wins over a shift in the same cycle, so a seed
	// written mid-word takes effect and that bit's step is dropped.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc_q <= `CCRC_RST_ACC;
		end else if (wr_acc) begin
			acc_q <= pwdata[15:0]; // [R1] [R10]
		end else if (cfg_q.go && state_q == ccrc_pkg::CCRC_SHIFT) begin
			acc_q <= crc_step(acc_q, data_bit, cfg_q.poly_len,
			                  taps_q); // [R7] [R20]
		end else if (cfg_q.go && state_q == ccrc_pkg::CCRC_AUG) begin
			acc_q <= crc_step(acc_q, 1'b0, cfg_q.poly_len,
			                  taps_q); // [R13] [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Completion flag.

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy;
		end
	end

	// The set term comes first so a clear in the same cycle cannot lose it.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if (busy_q && !busy) begin
			done_q <= 1'b1; // [R17]
		end else if (wr_irq && pwdata[`CCRC_IRQ_FLAG]) begin
			done_q <= 1'b0; // [R18]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ie_q <= 1'b0;
		end else if (wr_irq) begin
			ie_q <= pwdata[`CCRC_IRQ_ENABLE]; // [R19]
		end
	end

	assign irq = done_q & ie_q; // [R19]

	////////////////////////////////////////////////////////////////////////
	// Read path, captured in the setup cycle.

	// The error is judged in the setup cycle and stands through access.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= ~mapped;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					`CCRC_OFS_CTRL: begin
						prdata[`CCRC_CTRL_GO]      <= cfg_q.go;
						prdata[`CCRC_CTRL_AUGMENT] <= cfg_q.augment;
						prdata[`CCRC_CTRL_ORDER]   <= cfg_q.lsb_first;
						prdata[`CCRC_CTRL_BUSY]    <= busy; // [R25]
						prdata[`CCRC_CTRL_FULL]    <= full_q; // [R24]
					end
					`CCRC_OFS_LEN: begin
						prdata[`CCRC_LEN_WORD_LSB +: 4] <= cfg_q.word_len;
						prdata[`CCRC_LEN_POLY_LSB +: 4] <= cfg_q.poly_len;
					end
					`CCRC_OFS_WORD_HIGH: begin
						prdata[7:0] <= hold_q[15:8];
					end
					`CCRC_OFS_WORD_LOW: begin
						prdata[7:0] <= hold_q[7:0];
					end
					`CCRC_OFS_ACC: begin
						prdata[15:0] <= acc_q; // [R12]
					end
					`CCRC_OFS_TAPS: begin
						prdata[15:0] <= taps_q; // [R3]
					end
					`CCRC_OFS_IRQ: begin
						prdata[`CCRC_IRQ_FLAG]   <= done_q;
						prdata[`CCRC_IRQ_ENABLE] <= ie_q;
					end
					default: begin
						prdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

endmodule : ccrc_engine

// >>> verif/ccrc_engine_props.sv
/* Port checker for the CRC engine, bound to its top module.
   Assumes the register offsets of the design's map. */
`timescale 1ns/1ps
module ccrc_engine_props (
	// Clock, reset and bus.
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Scanner and interrupt.
	input wire ccrc_pkg::ccrc_scan_t scan_in,
	input wire logic                 scan_ready,
	input wire logic                 irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic setup, wr;
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	a_ready_tied: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	a_err_unmapped: assert property (setup && paddr > 8'h18 |=> pslverr)
		else $error("no error on unmapped");
	a_err_mapped: assert property (setup && paddr <= 8'h18
		&& paddr[1:0] == 2'b00 |=> !pslverr) else $error("false error");
	a_read_unmapped: assert property (setup && !pwrite && paddr > 8'h18
		|=> prdata == 32'h0) else $error("unmapped read not zero");
	a_taps_lsb: assert property (setup && !pwrite && paddr == 8'h14
		|=> !prdata[0]) else $error("tap bit 0 reads one");
	a_rdata_hold: assert property (!setup |=> $stable(prdata))
		else $error("read data moved");
	a_go_gate: assert property (wr && paddr == 8'h00
		&& !pwdata[0] |=> !scan_ready [*3]) else $error("ready while off");
	a_scan_take: assert property (scan_in.valid && scan_ready
		|=> !scan_ready) else $error("full not set on take");
	a_irq_gate: assert property (wr && paddr == 8'h18 && !pwdata[1]
		|=> !irq) else $error("irq while disabled");
	a_irq_hold: assert property (irq && !(wr && paddr == 8'h18)
		|=> irq) else $error("flag cleared by hardware");
	c_take: cover property (scan_in.valid && scan_ready);
	c_irq: cover property ($rose(irq));
	c_err: cover property (psel && penable && pslverr);
endmodule : ccrc_engine_props
bind ccrc_engine ccrc_engine_props i_ccrc_engine_props (.ref_clk(ref_clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .scan_in(scan_in), .scan_ready(scan_ready),
	.irq(irq));

// >>> verif/ccrc_scan_model.sv
/* Scanner model: hands queued words to the engine.
   Assumes the engine's clock and reset. */
`timescale 1ns/1ps
module ccrc_scan_model (
	// Clock and reset.
	input  wire logic            ref_clk,
	input  wire logic            rst,
	// Word handshake.
	input  wire logic            scan_ready,
	output ccrc_pkg::ccrc_scan_t scan_in
);
	logic [15:0] words[$];
	// Idle words toggle so that nothing can lean on a stale value.
	always @(posedge ref_clk) begin
		if (rst)
			scan_in <= '0;
		else if (!scan_in.valid || scan_ready) begin
			if (words.size() > 0)
				scan_in <= {1'b1, words.pop_front()};
			else
				scan_in <= {1'b0, ~scan_in.word};
		end
	end
endmodule : ccrc_scan_model

// >>> verif/ccrc_engine_test.sv
/* Self-checking bench of the CRC engine over APB and the scanner.
   Waits out any APB wait states and assumes a scanner model beside it. */
`timescale 1ns/1ps
`include "ccrc_map.svh"
module ccrc_engine_test;
	logic                 ref_clk, rst, psel, penable, pwrite, er;
	logic                 pready, pslverr, irq, scan_ready, od, ag;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, r;
	logic [15:0]          q[$], sd, tp;
	logic [3:0]           pl, wl;
	ccrc_pkg::ccrc_scan_t scan_in;
	int                   errors, checked, seed;
	localparam logic [31:0] DAT = 32'h55667788;
	ccrc_engine i_ccrc_engine (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scan_in(scan_in), .scan_ready(scan_ready), .irq(irq));
	ccrc_scan_model i_ccrc_scan_model (.ref_clk(ref_clk), .rst(rst),
		.scan_ready(scan_ready), .scan_in(scan_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// An idle cycle follows each transfer so no strobe is set twice at once.
	task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task automatic put(input logic [15:0] w);
		do bus(1'b0, `CCRC_OFS_CTRL, 0); while (r[4] !== 1'b0);
		bus(1'b1, `CCRC_OFS_WORD_HIGH, {24'h0, w[15:8]});
		bus(1'b1, `CCRC_OFS_WORD_LOW, {24'h0, w[7:0]});
	endtask : put
	task automatic cfg(input [15:0] s, t, input [3:0] p, w,
		input logic o, g, n);
		bus(1'b1, `CCRC_OFS_CTRL, 0);
		bus(1'b1, `CCRC_OFS_LEN, {24'h0, p, w});
		bus(1'b1, `CCRC_OFS_TAPS, {16'h0, t});
		bus(1'b0, `CCRC_OFS_TAPS, 0);
		chk(r, {16'h0, t & 16'hFFFE});
		bus(1'b1, `CCRC_OFS_ACC, {16'h0, s});
		bus(1'b1, `CCRC_OFS_IRQ, {30'h0, n, 1'b1});
		bus(1'b1, `CCRC_OFS_CTRL, {29'h0, o, g, 1'b1});
	endtask : cfg
	task automatic done(input logic [15:0] e, input logic n);
		do bus(1'b0, `CCRC_OFS_CTRL, 0); while (r[3] !== 1'b0);
		bus(1'b0, `CCRC_OFS_ACC, 0);
		chk(r, {16'h0, e});
		bus(1'b0, `CCRC_OFS_IRQ, 0);
		chk(r[0], 1);
		chk(irq, n);
		bus(1'b1, `CCRC_OFS_IRQ, {30'h0, n, 1'b1});
		bus(1'b0, `CCRC_OFS_IRQ, 0);
		chk(r[0], 0);
	endtask : done
	function automatic logic [15:0] crc(input [15:0] a, t,
		input [3:0] p, w, input logic o, g);
		logic [15:0] m;
		logic        f;
		m = 16'hFFFF >> (4'hF - p);
		t = (t | 16'h0001) & m;
		foreach (q[k])
			for (int i = 0; i <= w; i++) begin
				f = a[p];
				a = ((a << 1) | q[k][o ? i : w - i]) & m;
				if (f) a = a ^ t;
			end
		for (int i = 0; g && i <= p; i++) begin
			f = a[p];
			a = (a << 1) & m;
			if (f) a = a ^ t;
		end
		return a;
	endfunction : crc
	task automatic close_out;
		$display("Comparisons %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	initial begin
		#500000;
		errors++;
		close_out;
	end
	initial begin
		seed = 32'h4f21;
		{rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		bus(1'b0, `CCRC_OFS_ACC, 0);
		chk(r, `CCRC_RST_ACC);
		bus(1'b0, 8'h1C, 0);
		chk({r[30:0], er}, 1);
		for (int k = 0; k < 2; k++) begin
			cfg(0, 16'h8004, 4'hF, 4'h7, k[0], 1'b1, 1'b1);
			for (int i = 3; i >= 0; i--)
				put({8'($random(seed)), DAT[8 * i +: 8]});
			done(k ? 16'h6BA2 : 16'h32D6, 1'b1);
		end
		bus(1'b0, `CCRC_OFS_ACC, 0);
		sd = r[15:0];
		cfg(0, 16'h0000, 4'hF, 4'hF, 1'b1, 1'b1, 1'b1);
		put(sd);
		done(16'h45D6, 1'b1);
		repeat (12) begin
			{sd, tp} = $random(seed);
			{pl, od, ag} = 6'($random(seed));
			wl = {2'b11, 2'($random(seed))};
			q = {};
			repeat (1 + ($random(seed) & 3)) q.push_back(16'($random(seed)));
			cfg(sd, tp, pl, wl, od, ag, 1'b0);
			foreach (q[i]) put(q[i]);
			done(crc(sd, tp, pl, wl, od, ag), 1'b0);
		end
		bus(1'b1, `CCRC_OFS_CTRL, 0);
		bus(1'b0, `CCRC_OFS_ACC, 0);
		sd = r[15:0];
		put(16'hA5A5);
		repeat (30) @(posedge ref_clk);
		bus(1'b0, `CCRC_OFS_ACC, 0);
		chk(r, {16'h0, sd});
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		for (int i = 3; i >= 0; i--)
			i_ccrc_scan_model.words.push_back({8'($random(seed)),
				DAT[8 * i +: 8]});
		cfg(0, 16'h8004, 4'hF, 4'h7, 1'b0, 1'b1, 1'b1);
		done(16'h32D6, 1'b1);
		close_out;
	end
endmodule : ccrc_engine_test
